// [hdl/host_bus_device.sv]
// Device end of the host parallel bus port
`timescale 1ns/1ps
`default_nettype none
module host_bus_device
  import host_bus_pkg::*;
#(
  parameter int HOLDOFF_LONG = HOLDOFF_LONG_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Host pins
  host_bus_if.device             bus,
  // Bus mode strap
  input  wire bus_mode_e         mode,
  // Local memory port
  output logic                   acc_valid,
  output logic                   acc_write,
  output logic [ADDR_W-1:0]      acc_addr,
  output logic [DATA_W-1:0]      acc_wdata,
  input  wire logic [DATA_W-1:0] acc_rdata,
  // Interrupt
  input  wire logic              irq_req,
  input  wire logic              int_ack,
  input  wire logic              holdoff_unit
);

  typedef enum logic [2:0] {D_IDLE, D_RD_WAIT, D_RD_DRIVE, D_WR_WAIT, D_WR_READY} dev_state_e;

  logic [CTL_W-1:0]  ctl_s1_q;
  logic [CTL_W-1:0]  ctl_s2_q;
  logic [CTL_W-1:0]  ctl_prv_q;
  logic [PIN_W-1:0]  dat_s1_q;
  logic [PIN_W-1:0]  dat_s2_q;
  logic [1:0]        div_cnt_q;
  logic              clkout_q;
  logic [HI_W-1:0]   hi_q;
  logic [LO_W-1:0]   lo_q;
  logic              cs_mux_q;
  dev_state_e        state_q;
  dev_state_e        state_d;
  logic [WAIT_W-1:0] wait_q;
  logic [WAIT_W-1:0] wait_d;
  logic              acc_valid_q;
  logic              acc_write_q;
  logic [ADDR_W-1:0] acc_addr_q;
  logic [DATA_W-1:0] acc_wdata_q;
  logic [DATA_W-1:0] dout_q;
  logic              oe_q;
  logic              done_n_q;
  logic [HOLD_W-1:0] hold_q;
  logic              int_n_q;

  function automatic logic cs_decode(input logic [HI_W-1:0] hi);
    cs_decode = (hi[HI_W-1] == CS_MATCH);
  endfunction

  // All pins cross into clk through two flops before any use
  wire logic [CTL_W-1:0] ctl_raw = {bus.reset_n, bus.divider_sel, bus.addr_latch,
                                    bus.read_strobe_n, bus.write_strobe_n,
                                    bus.chip_select_n, bus.read_not_write, bus.phase_clk};
  wire logic [PIN_W-1:0] dat_raw = {bus.addr_hi, bus.addr_lo, bus.ad};

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_s1_q  <= CTL_RST_VAL;
      ctl_s2_q  <= CTL_RST_VAL;
      ctl_prv_q <= CTL_RST_VAL;
      dat_s1_q  <= '0;
      dat_s2_q  <= '0;
    end else begin
      ctl_s1_q  <= ctl_raw;
      ctl_s2_q  <= ctl_s1_q;
      ctl_prv_q <= ctl_s2_q;
      dat_s1_q  <= dat_raw;
      dat_s2_q  <= dat_s1_q;
    end
  end

  // Pin levels are read active low where named so
  wire logic [CTL_W-1:0]  ctl_fall = ctl_prv_q & ~ctl_s2_q;
  wire logic [CTL_W-1:0]  ctl_rise = ~ctl_prv_q & ctl_s2_q;
  wire logic              lrst     = rst | ~ctl_s2_q[CTL_RST];
  wire logic [HI_W-1:0]   pin_hi   = dat_s2_q[PIN_W-1 -: HI_W];
  wire logic [LO_W-1:0]   pin_lo   = dat_s2_q[DATA_W +: LO_W];
  wire logic [DATA_W-1:0] pin_ad   = dat_s2_q[DATA_W-1:0];
  wire logic              pin_cs   = ~ctl_s2_q[CTL_CS];
  wire logic              pin_rnw  = ctl_s2_q[CTL_RNW];

  wire logic is_mux   = (mode == MODE_MUX_SYNC);
  wire logic is_async = (mode == MODE_ASYNC);
  wire logic is_phase = (mode == MODE_PHASE);

  // Clock for the host: divide by 4 with the select low, else by 2
  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_q <= 2'h0;
      clkout_q  <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_q + 2'h1;
      clkout_q  <= ctl_s2_q[CTL_DIV] ? div_cnt_q[0] : div_cnt_q[1];
    end
  end

  // Mux mode: low address shares the data pins, high bits sampled together
  always_ff @(posedge clk) begin
    if (lrst) begin
      hi_q     <= '0;
      lo_q     <= '0;
      cs_mux_q <= 1'b0;
    end else if (is_mux && ctl_fall[CTL_LAT]) begin
      hi_q     <= pin_hi;
      lo_q     <= pin_ad;
      cs_mux_q <= cs_decode(pin_hi);
    end
  end

  wire logic sel = is_mux ? cs_mux_q : pin_cs;
  wire logic [ADDR_W-1:0] cur_addr = is_mux ? {hi_q[HI_W-2:0], lo_q} : {pin_hi[HI_W-2:0], pin_lo};

  // Access starts per mode
  wire logic rd_go = is_phase ? (ctl_rise[CTL_PH] & pin_cs & pin_rnw)
                              : (ctl_fall[CTL_RD] & sel);
  wire logic wr_now = is_phase ? (ctl_fall[CTL_PH] & pin_cs & ~pin_rnw)
                               : (is_mux & ctl_rise[CTL_WR] & sel);
  wire logic wr_async_go = is_async & ctl_fall[CTL_WR] & sel;
  wire logic wr_pending  = (state_q == D_WR_WAIT) || (state_q == D_WR_READY);
  wire logic rd_take     = (state_q == D_IDLE) & rd_go;
  // Strobe-mode write commits on the rising strobe, even before ready
  wire logic wr_take = ((state_q == D_IDLE) & ~rd_go & wr_now)
                     | (wr_pending & ctl_rise[CTL_WR]);
  wire logic rd_end  = is_phase ? ~ctl_s2_q[CTL_PH] : ctl_s2_q[CTL_RD];

  always_comb begin
    state_d = state_q;
    wait_d  = (wait_q == '0) ? wait_q : wait_q - 1'b1;
    case (state_q)
      D_IDLE: begin
        if (rd_go) begin
          state_d = D_RD_WAIT;
          wait_d  = WAIT_W'(READ_WAIT_CYC);
        end else if (wr_async_go) begin
          state_d = D_WR_WAIT;
          wait_d  = WAIT_W'(WRITE_WAIT_CYC);
        end
      end
      D_RD_WAIT: begin
        if (rd_end) begin
          state_d = D_IDLE;
        end else if (wait_q == '0) begin
          state_d = D_RD_DRIVE;
        end
      end
      D_RD_DRIVE: begin
        if (rd_end) begin
          state_d = D_IDLE;
        end
      end
      D_WR_WAIT: begin
        if (ctl_rise[CTL_WR]) begin
          state_d = D_IDLE;
        end else if (wait_q == '0) begin
          state_d = D_WR_READY;
        end
      end
      D_WR_READY: begin
        if (ctl_rise[CTL_WR]) begin
          state_d = D_IDLE;
        end
      end
      default: begin
        state_d = D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (lrst) begin
      state_q <= D_IDLE;
      wait_q  <= '0;
    end else begin
      state_q <= state_d;
      wait_q  <= wait_d;
    end
  end

  // Local memory request, one pulse per host access
  always_ff @(posedge clk) begin
    if (lrst) begin
      acc_valid_q <= 1'b0;
      acc_write_q <= 1'b0;
      acc_addr_q  <= '0;
      acc_wdata_q <= '0;
    end else begin
      acc_valid_q <= rd_take | wr_take;
      if (rd_take || wr_take) begin
        acc_write_q <= wr_take;
        acc_addr_q  <= cur_addr;
        acc_wdata_q <= pin_ad;
      end
    end
  end

  // Ready is a clk-registered level, so it never glitches on the pin
  wire logic drive_d = (state_d == D_RD_DRIVE);
  wire logic ready_d = is_async & (drive_d | (state_d == D_WR_READY));

  always_ff @(posedge clk) begin
    if (lrst) begin
      dout_q   <= '0;
      oe_q     <= 1'b0;
      done_n_q <= 1'b1;
    end else begin
      if (state_q == D_RD_WAIT && wait_q == '0) begin
        dout_q <= acc_rdata;
      end
      oe_q     <= drive_d;
      done_n_q <= ~ready_d;
    end
  end

  // Holdoff after acknowledge; a new acknowledge restarts it
  always_ff @(posedge clk) begin
    if (lrst) begin
      hold_q  <= '0;
      int_n_q <= 1'b1;
    end else begin
      if (int_ack) begin
        hold_q <= holdoff_unit ? HOLD_W'(HOLDOFF_LONG) : HOLD_W'(HOLDOFF_SHORT_CYC);
      end else if (hold_q != '0) begin
        hold_q <= hold_q - 1'b1;
      end
      int_n_q <= ~(irq_req & ~int_ack & (hold_q == '0));
    end
  end

  assign acc_valid             = acc_valid_q;
  assign acc_write             = acc_write_q;
  assign acc_addr              = acc_addr_q;
  assign acc_wdata             = acc_wdata_q;
  assign bus.ad_dev_o          = dout_q;
  assign bus.ad_dev_oe         = oe_q;
  assign bus.access_done_n     = done_n_q;
  assign bus.int_n             = int_n_q;
  assign bus.divided_clock_out = clkout_q;

endmodule
`default_nettype wire

// [hdl/host_bus_pkg.sv]
// Shared constants and types for the host parallel bus port and its host end
package host_bus_pkg;
  // Bus widths
  localparam int HI_W   = 4;
  localparam int LO_W   = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = HI_W - 1 + LO_W;
  localparam int PIN_W  = HI_W + LO_W + DATA_W;
  // Mux mode: top high address bit value that selects the device
  localparam logic CS_MATCH = 1'h0;
  // Clock and timing
  localparam int CLK_MHZ           = 250;
  localparam int HOLDOFF_SHORT_NS  = 1000;
  localparam int HOLDOFF_LONG_US   = 1000;
  localparam int HOLDOFF_SHORT_CYC = (HOLDOFF_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLDOFF_LONG_CYC  = HOLDOFF_LONG_US * CLK_MHZ;
  localparam int HOLD_W            = 18;
  localparam int RESET_MIN_NS      = 100;
  localparam int RESET_MIN_CYC     = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PHASE_DIV         = 4;
  localparam int PH_HALF_EDGES     = PHASE_DIV / 2;
  // Device access latency
  localparam int READ_WAIT_CYC  = 2;
  localparam int WRITE_WAIT_CYC = 4;
  localparam int WAIT_W         = 3;
  // Host sequencing
  localparam int LATCH_CYC  = 4;
  localparam int AHOLD_CYC  = 4;
  localparam int STROBE_CYC = 12;
  localparam int TAIL_CYC   = 4;
  localparam int CNT_W      = 5;
  // Device control pin positions in the synchroniser
  localparam int CTL_PH  = 0;
  localparam int CTL_RNW = 1;
  localparam int CTL_CS  = 2;
  localparam int CTL_WR  = 3;
  localparam int CTL_RD  = 4;
  localparam int CTL_LAT = 5;
  localparam int CTL_DIV = 6;
  localparam int CTL_RST = 7;
  localparam int CTL_W   = 8;
  localparam logic [CTL_W-1:0] CTL_RST_VAL = 8'h9c;
  // Host input pin positions in the synchroniser
  localparam int HIN_DONE = 0;
  localparam int HIN_INT  = 1;
  localparam int HIN_CLK  = 2;
  localparam int HIN_W    = 3;
  localparam logic [HIN_W-1:0] HIN_RST_VAL = 3'h3;
  typedef enum logic [1:0] {MODE_MUX_SYNC, MODE_ASYNC, MODE_PHASE} bus_mode_e;
endpackage

// [hdl/host_bus_if.sv]
// Pin-level carrier between the device port and the host
`timescale 1ns/1ps
`default_nettype none
interface host_bus_if
  import host_bus_pkg::*;
();
  logic              addr_latch;
  logic              read_strobe_n;
  logic              write_strobe_n;
  logic              chip_select_n;
  logic              phase_clk;
  logic              read_not_write;
  logic              divider_sel;
  logic              reset_n;
  logic [HI_W-1:0]   addr_hi;
  logic [LO_W-1:0]   addr_lo;
  logic [DATA_W-1:0] ad_host_o;
  logic              ad_host_oe;
  logic [DATA_W-1:0] ad_dev_o;
  logic              ad_dev_oe;
  logic [DATA_W-1:0] ad;
  logic              access_done_n;
  logic              int_n;
  logic              divided_clock_out;

  // Undriven bus floats high as with a pull-up
  assign ad = ad_dev_oe ? ad_dev_o : (ad_host_oe ? ad_host_o : '1);

  modport device (
    input  addr_latch, read_strobe_n, write_strobe_n, chip_select_n, phase_clk,
    input  read_not_write, divider_sel, reset_n, addr_hi, addr_lo, ad,
    output ad_dev_o, ad_dev_oe, access_done_n, int_n, divided_clock_out
  );
  modport host (
    output addr_latch, read_strobe_n, write_strobe_n, chip_select_n, phase_clk,
    output read_not_write, divider_sel, reset_n, addr_hi, addr_lo,
    output ad_host_o, ad_host_oe,
    input  ad, access_done_n, int_n, divided_clock_out
  );
endinterface
`default_nettype wire

// [hdl/host_bus_host.sv]
// Host end driving the parallel bus port
`timescale 1ns/1ps
`default_nettype none
module host_bus_host
  import host_bus_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Device pins
  host_bus_if.host                  bus,
  // Bus mode strap
  input  wire bus_mode_e            mode,
  // Command
  input  wire logic                 cmd_valid,
  input  wire logic                 cmd_write,
  input  wire logic [HI_W+LO_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0]    cmd_wdata,
  output logic                      cmd_ready,
  // Response
  output logic                      rsp_valid,
  output logic [DATA_W-1:0]         rsp_rdata,
  output logic                      irq
);

  typedef enum logic [3:0] {H_RESET, H_IDLE, H_LATCH, H_AHOLD, H_STROBE, H_WAIT_DONE,
                            H_WAIT_REL, H_PH_WAIT, H_PH_SETUP, H_PH_HIGH, H_TAIL} host_state_e;

  logic [HIN_W-1:0]       in_s1_q;
  logic [HIN_W-1:0]       in_s2_q;
  logic [DATA_W-1:0]      ad_s1_q;
  logic [DATA_W-1:0]      ad_s2_q;
  logic                   ck_prv_q;
  logic                   edge_q;
  logic                   ph_q;
  logic                   ph_prv_q;
  host_state_e            state_q;
  host_state_e            state_d;
  logic [CNT_W-1:0]       cnt_q;
  logic [CNT_W-1:0]       cnt_d;
  logic                   cw_q;
  logic [HI_W+LO_W-1:0]   ca_q;
  logic [DATA_W-1:0]      cd_q;
  logic                   lat_q;
  logic                   rd_n_q;
  logic                   wr_n_q;
  logic                   cs_n_q;
  logic                   rnw_q;
  logic                   rst_n_q;
  logic [DATA_W-1:0]      ado_q;
  logic                   adoe_q;
  logic                   ready_q;
  logic                   rsp_valid_q;
  logic [DATA_W-1:0]      rsp_rdata_q;
  logic                   irq_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      in_s1_q  <= HIN_RST_VAL;
      in_s2_q  <= HIN_RST_VAL;
      ad_s1_q  <= '1;
      ad_s2_q  <= '1;
      ck_prv_q <= 1'b0;
    end else begin
      in_s1_q  <= {bus.divided_clock_out, bus.int_n, bus.access_done_n};
      in_s2_q  <= in_s1_q;
      ad_s1_q  <= bus.ad;
      ad_s2_q  <= ad_s1_q;
      ck_prv_q <= in_s2_q[HIN_CLK];
    end
  end

  wire logic done_s  = ~in_s2_q[HIN_DONE];
  wire logic ck_rise = in_s2_q[HIN_CLK] & ~ck_prv_q;

  // Phase clock is the device clock output divided by four
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_q   <= 1'b0;
      ph_q     <= 1'b0;
      ph_prv_q <= 1'b0;
    end else begin
      ph_prv_q <= ph_q;
      if (ck_rise) begin
        edge_q <= (edge_q == 1'(PH_HALF_EDGES - 1)) ? 1'b0 : edge_q + 1'b1;
        ph_q   <= (edge_q == 1'(PH_HALF_EDGES - 1)) ? ~ph_q : ph_q;
      end
    end
  end

  wire logic is_mux   = (mode == MODE_MUX_SYNC);
  wire logic is_async = (mode == MODE_ASYNC);
  wire logic is_phase = (mode == MODE_PHASE);
  wire logic ph_rose  = ph_q & ~ph_prv_q;
  wire logic ph_fell  = ~ph_q & ph_prv_q;
  wire logic take     = (state_q == H_IDLE) & cmd_valid;

  always_comb begin
    state_d = state_q;
    cnt_d   = (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
    case (state_q)
      H_RESET: if (cnt_q == '0) state_d = H_IDLE;
      H_IDLE: begin
        if (cmd_valid) begin
          if (is_mux) begin
            state_d = H_LATCH;
            cnt_d   = CNT_W'(LATCH_CYC - 1);
          end else if (is_async) begin
            state_d = H_WAIT_DONE;
          end else begin
            state_d = H_PH_WAIT;
          end
        end
      end
      H_LATCH: if (cnt_q == '0) begin
        state_d = H_AHOLD;
        cnt_d   = CNT_W'(AHOLD_CYC - 1);
      end
      H_AHOLD: if (cnt_q == '0) begin
        state_d = H_STROBE;
        cnt_d   = CNT_W'(STROBE_CYC - 1);
      end
      H_STROBE: if (cnt_q == '0) begin
        state_d = H_TAIL;
        cnt_d   = CNT_W'(TAIL_CYC - 1);
      end
      H_WAIT_DONE: if (done_s) state_d = H_WAIT_REL;
      H_WAIT_REL: if (!done_s) begin
        state_d = H_TAIL;
        cnt_d   = CNT_W'(TAIL_CYC - 1);
      end
      H_PH_WAIT: if (!ph_q) state_d = H_PH_SETUP;
      H_PH_SETUP: if (ph_rose) state_d = H_PH_HIGH;
      H_PH_HIGH: if (ph_fell) begin
        state_d = H_TAIL;
        cnt_d   = CNT_W'(TAIL_CYC - 1);
      end
      H_TAIL: if (cnt_q == '0) state_d = H_IDLE;
      default: state_d = H_IDLE;
    endcase
  end

  // Pin decode from the next state keeps every pin but the tied-low divider select a flop output
  wire logic                 cw_d   = take ? cmd_write : cw_q;
  wire logic [HI_W+LO_W-1:0] ca_d   = take ? cmd_addr : ca_q;
  wire logic [DATA_W-1:0]    cd_d   = take ? cmd_wdata : cd_q;
  wire logic                 strobe = (state_d == H_STROBE) || (state_d == H_WAIT_DONE);
  wire logic                 alat   = (state_d == H_LATCH) || (state_d == H_AHOLD);
  wire logic                 busy   = strobe || (state_d == H_WAIT_REL) || (state_d == H_PH_SETUP)
                                   || (state_d == H_PH_HIGH) || (state_d == H_TAIL);
  wire logic                 fin    = (state_q == H_TAIL) && (cnt_q == '0);
  wire logic                 cap    = ~cw_q & (((state_q == H_STROBE) && (cnt_q == '0))
                                   || ((state_q == H_WAIT_DONE) && done_s) || (is_phase && fin));

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= H_RESET;
      cnt_q   <= CNT_W'(RESET_MIN_CYC - 1);
      cw_q    <= 1'b0;
      ca_q    <= '0;
      cd_q    <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      cw_q    <= cw_d;
      ca_q    <= ca_d;
      cd_q    <= cd_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lat_q   <= 1'b0;
      rd_n_q  <= 1'b1;
      wr_n_q  <= 1'b1;
      cs_n_q  <= 1'b1;
      rnw_q   <= 1'b1;
      rst_n_q <= 1'b0;
      ado_q   <= '0;
      adoe_q  <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      lat_q   <= (state_d == H_LATCH);
      rd_n_q  <= ~(strobe & ~cw_d);
      wr_n_q  <= ~(strobe & cw_d);
      cs_n_q  <= is_mux | ~busy;
      rnw_q   <= ~cw_d;
      rst_n_q <= (state_d != H_RESET);
      ado_q   <= alat ? ca_d[LO_W-1:0] : cd_d;
      adoe_q  <= (is_mux & alat) | (cw_d & busy);
      ready_q <= (state_d == H_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= '0;
      irq_q       <= 1'b0;
    end else begin
      rsp_valid_q <= fin;
      if (cap) rsp_rdata_q <= ad_s2_q;
      irq_q       <= ~in_s2_q[HIN_INT];
    end
  end

  assign cmd_ready          = ready_q;
  assign rsp_valid          = rsp_valid_q;
  assign rsp_rdata          = rsp_rdata_q;
  assign irq                = irq_q;
  assign bus.addr_latch     = lat_q;
  assign bus.read_strobe_n  = rd_n_q;
  assign bus.write_strobe_n = wr_n_q;
  assign bus.chip_select_n  = cs_n_q;
  assign bus.phase_clk      = ph_q;
  assign bus.read_not_write = rnw_q;
  assign bus.divider_sel    = 1'b0;
  assign bus.reset_n        = rst_n_q;
  assign bus.addr_hi        = ca_q[HI_W+LO_W-1:LO_W];
  assign bus.addr_lo        = ca_q[LO_W-1:0];
  assign bus.ad_host_o      = ado_q;
  assign bus.ad_host_oe     = adoe_q;

endmodule
`default_nettype wire

// [sim/host_bus_props.sv]
// Pin-level assertions on the link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module host_bus_props
  import host_bus_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus mode strap
  input wire bus_mode_e mode,
  // Host driven pins
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chip_select_n,
  input wire logic phase_clk,
  input wire logic read_not_write,
  input wire logic divider_sel,
  input wire logic reset_n,
  input wire logic ad_host_oe,
  // Device driven pins
  input wire logic ad_dev_oe,
  input wire logic access_done_n,
  input wire logic divided_clock_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  no_contention_a: assert property (!(ad_dev_oe && ad_host_oe))
    else $error("both ends drive the data bus");
  idle_tristate_a: assert property ((read_strobe_n && chip_select_n) [*5] |-> !ad_dev_oe)
    else $error("data bus driven with read strobe high");
  ready_drop_a: assert property ((read_strobe_n && write_strobe_n) [*5] |-> access_done_n)
    else $error("ready held after strobe release");
  ready_cause_a: assert property ($fell(access_done_n) |-> !read_strobe_n || !write_strobe_n)
    else $error("ready without an access strobe");
  async_latency_a: assert property (($fell(read_strobe_n) || $fell(write_strobe_n)) && !chip_select_n
    |-> ##[6:8] !access_done_n)
    else $error("ready late in strobe mode");
  mux_read_a: assert property ($fell(read_strobe_n) && chip_select_n |-> ##[6:8] ad_dev_oe)
    else $error("mux read not answered");
  phase_read_a: assert property (mode == MODE_PHASE && $rose(phase_clk) && !chip_select_n && read_not_write
    && read_strobe_n && write_strobe_n |-> ##[6:8] ad_dev_oe)
    else $error("phase read not answered");
  reset_width_a: assert property ($rose(reset_n) |-> $past(reset_n, 25) == 1'b0)
    else $error("device reset pulse too short");
  clock_div_a: assert property ($rose(divided_clock_out) && !divider_sel
    |-> ##2 $fell(divided_clock_out) ##2 $rose(divided_clock_out))
    else $error("clock output not divide by four");
endmodule
`default_nettype wire

// [sim/host_bus_interface_tb.sv]
// Testbench joining host and device ends of the parallel bus port
`timescale 1ns/1ps
`default_nettype none
module host_bus_interface_tb
  import host_bus_pkg::*;
;
  localparam int HOLD_SIM = 300;
  localparam int LIMIT    = 20000;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  bus_mode_e            mode = MODE_MUX_SYNC;
  logic                 cmd_valid = 1'b0;
  logic                 cmd_write = 1'b0;
  logic [HI_W+LO_W-1:0] cmd_addr = '0;
  logic [DATA_W-1:0]    cmd_wdata = '0;
  logic                 cmd_ready, rsp_valid, irq, acc_valid, acc_write, acc2_valid;
  logic [DATA_W-1:0]    rsp_rdata, acc_wdata, rd;
  logic [ADDR_W-1:0]    acc_addr;
  logic [DATA_W-1:0]    acc_rdata = '0;
  logic                 irq_req = 1'b0;
  logic                 int_ack = 1'b0;
  logic                 holdoff_unit = 1'b0;
  logic                 oe2_seen = 1'b0;
  logic                 acc2_seen = 1'b0;
  logic [DATA_W-1:0]    mem [2**ADDR_W];
  int                   acc_cnt = 0;
  int                   c0, cycles = 0, comparisons = 0, miscompares = 0;
  // Rows: write flag, command address, data written or read back
  logic [20:0] rows [4] = '{{1'b1, 12'h005, 8'ha5}, {1'b1, 12'h7ff, 8'h3c},
                            {1'b0, 12'h005, 8'ha5}, {1'b0, 12'h7ff, 8'h3c}};

  host_bus_if bus ();
  host_bus_if bus2 ();
  host_bus_device #(.HOLDOFF_LONG(HOLD_SIM)) host_bus_device_inst (.clk(clk), .rst(rst), .bus(bus.device),
    .mode(mode), .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .irq_req(irq_req), .int_ack(int_ack), .holdoff_unit(holdoff_unit));
  host_bus_host host_bus_host_inst (.clk(clk), .rst(rst), .bus(bus.host), .mode(mode), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .irq(irq));
  // Second device faces a bench driver that drops its strobe early
  host_bus_device #(.HOLDOFF_LONG(HOLD_SIM)) host_bus_device_inst2 (.clk(clk), .rst(rst), .bus(bus2.device),
    .mode(MODE_ASYNC), .acc_valid(acc2_valid), .acc_write(), .acc_addr(), .acc_wdata(),
    .acc_rdata(8'h00), .irq_req(1'b0), .int_ack(1'b0), .holdoff_unit(1'b0));
  host_bus_props host_bus_props_inst (.clk(clk), .rst(rst), .read_strobe_n(bus.read_strobe_n),
    .write_strobe_n(bus.write_strobe_n), .chip_select_n(bus.chip_select_n), .phase_clk(bus.phase_clk),
    .read_not_write(bus.read_not_write), .divider_sel(bus.divider_sel), .reset_n(bus.reset_n),
    .ad_host_oe(bus.ad_host_oe), .ad_dev_oe(bus.ad_dev_oe), .access_done_n(bus.access_done_n),
    .divided_clock_out(bus.divided_clock_out), .mode(mode));

  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    {bus2.addr_latch, bus2.phase_clk, bus2.divider_sel, bus2.ad_host_oe} = 4'h0;
    {bus2.read_strobe_n, bus2.write_strobe_n, bus2.chip_select_n, bus2.reset_n, bus2.read_not_write} = 5'h1f;
    {bus2.addr_hi, bus2.addr_lo, bus2.ad_host_o} = '0;
  end
  // Local memory behind the device; read data stands until the next access
  always @(negedge clk) begin
    if (acc_valid === 1'b1) begin
      acc_cnt <= acc_cnt + 1;
      if (acc_write) mem[acc_addr] <= acc_wdata;
    end
    acc_rdata <= mem[acc_addr];
  end
  always @(posedge clk) begin
    if (bus2.ad_dev_oe === 1'b1) oe2_seen <= 1'b1;
    if (acc2_valid === 1'b1) acc2_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      end_of_test();
    end
  end

  task chk(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task do_reset(input bus_mode_e m);
    rst = 1'b1;
    mode = m;
    repeat (4) @(negedge clk);
    chk(bus.int_n === 1'b1 && bus.access_done_n === 1'b1 && bus.ad_dev_oe === 1'b0, "device not idle");
    chk(bus.reset_n === 1'b0 && cmd_ready === 1'b0 && acc_valid === 1'b0, "host not in reset");
    rst = 1'b0;
  endtask
  task do_cmd(input logic w, input logic [HI_W+LO_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'b1, w, a, d};
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(n < 200, "no response");
    rd = rsp_rdata;
  endtask
  // Counts from the acknowledge until the interrupt shows again
  task holdoff(input logic unit, input int len);
    int n;
    irq_req = 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    holdoff_unit = unit;
    int_ack = 1'b1;
    @(negedge clk);
    int_ack = 1'b0;
    repeat (5) @(negedge clk);
    chk(irq === 1'b0, "interrupt not held off");
    n = 5;
    while (irq !== 1'b1 && n < len + 50) begin
      @(negedge clk);
      n++;
    end
    chk(n >= len && n <= len + 8, "holdoff length");
  endtask

  initial begin
    for (int m = 0; m < 3; m++) begin
      do_reset(bus_mode_e'(m));
      chk(bus.divider_sel === 1'b0, "divider pin not low");
      for (int i = 0; i < 4; i++) begin
        c0 = acc_cnt;
        do_cmd(rows[i][20], rows[i][19:8], rows[i][7:0]);
        @(negedge clk);
        chk(acc_cnt == c0 + 1 && acc_write === rows[i][20], "access count");
        if (rows[i][20]) chk(acc_addr === rows[i][18:8] && acc_wdata === rows[i][7:0], "write fields");
        else chk(rd === rows[i][7:0] && acc_addr === rows[i][18:8], "read data");
        chk(bus.ad === 8'hff, "bus not released");
      end
    end
    do_reset(MODE_MUX_SYNC);
    c0 = acc_cnt;
    do_cmd(1'b1, 12'h805, 8'h11);
    do_cmd(1'b0, 12'h005, 8'h00);
    chk(acc_cnt == c0 + 1 && rd === 8'ha5, "deselected write taken");
    holdoff(1'b0, HOLDOFF_SHORT_CYC);
    holdoff(1'b1, HOLD_SIM);
    irq_req = 1'b0;
    repeat (10) @(negedge clk);
    chk(irq === 1'b0 && bus.int_n === 1'b1, "interrupt stuck");
    {bus2.chip_select_n, bus2.read_strobe_n} = 2'h0;
    repeat (2) @(negedge clk);
    bus2.read_strobe_n = 1'b1;
    repeat (20) @(negedge clk);
    chk(!oe2_seen && bus2.access_done_n === 1'b1, "aborted read drove bus");
    chk(acc2_seen === 1'b1, "aborted read never started");
    end_of_test();
  end
endmodule
`default_nettype wire
